//--- rtl/brm_pkg.sv
// Package for the six-bit binary rate multiplier: register map, fields, widths
package brm_pkg;
    // ==========================================================================
    // Widths
    // ==========================================================================
    localparam int BRM_CNT_W = 6;
    localparam int BRM_ADDR_W = 8;
    localparam int BRM_DATA_W = 32;

    // ==========================================================================
    // Register byte offsets
    // ==========================================================================
    localparam logic [7:0] BRM_OFF_CTRL = 8'h00;
    localparam logic [7:0] BRM_OFF_RATE = 8'h04;
    localparam logic [7:0] BRM_OFF_STATUS = 8'h08;
    localparam logic [7:0] BRM_OFF_PULSES = 8'h0c;

    // ==========================================================================
    // Control field positions and reset values
    // ==========================================================================
    localparam int BRM_CTRL_CLEAR = 0;
    localparam int BRM_CTRL_HALT = 1;
    localparam int BRM_CTRL_STROBE = 2;
    localparam int BRM_CTRL_UNITY = 3;
    localparam int BRM_CTRL_UNITY_PIN = 4;
    localparam int BRM_CTRL_W = 5;
    localparam logic [4:0] BRM_CTRL_RST = 5'h08;
    localparam logic [5:0] BRM_RATE_RST = 6'h00;
    localparam logic [5:0] BRM_CNT_MAX = 6'h3f;
    localparam logic [5:0] BRM_CNT_ZERO = 6'h00;
    localparam int BRM_STAT_ENA = 8;
    localparam int BRM_STAT_Z = 9;
    localparam int BRM_STAT_Y = 10;

    // ==========================================================================
    // Effective controls, merged from register and pins
    // ==========================================================================
    typedef struct packed {
        logic clear;
        logic halt;
        logic strobe;
        logic unity;
    } brm_ctl_s;
endpackage : brm_pkg

//--- rtl/brm_top.sv
// Six-bit synchronous binary rate multiplier with an APB register port
module brm_top
    import brm_pkg::*;
#(
    parameter int CNT_W = BRM_CNT_W
)
(
    input wire logic pclk, // APB clock, 100 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high for write
    input wire logic [BRM_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [BRM_DATA_W-1:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [BRM_DATA_W-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic clock_tick, // One-cycle enable: rising edge of the input clock
    input wire logic clear_in, // Clear pin, active high
    input wire logic count_enable_n_in, // Count-enable pin, active low
    input wire logic strobe_in, // Strobe pin, active high
    input wire logic unity_cascade_in, // Unity/cascade pin
    output logic z_n, // Rate pulse output, active low
    output logic y_out, // Complementary pulse output
    output logic enable_n_out // Cascade enable output, active low
);

    // ==========================================================================
    // Parameter check
    // ==========================================================================
    // The rate decode is written for six binary stages only
    if (CNT_W != BRM_CNT_W)
    begin : g_bad_width
        $error("brm_top: counter width must be six");
    end

    // ==========================================================================
    // State
    // ==========================================================================
    logic [BRM_CTRL_W-1:0] ctrl;
    logic [BRM_CTRL_W-1:0] next_ctrl;
    logic [BRM_CNT_W-1:0] rate;
    logic [BRM_CNT_W-1:0] next_rate;
    logic [BRM_CNT_W-1:0] cnt;
    logic [BRM_CNT_W-1:0] next_cnt;
    logic [15:0] pulses;
    logic [15:0] next_pulses;
    logic [BRM_DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_z_n;
    logic next_y_out;
    logic next_enable_n_out;
    brm_ctl_s ctl;
    logic [BRM_CNT_W-1:0] hit;
    logic rate_hit;
    logic setup;
    logic mapped;

    // ==========================================================================
    // Merged controls: register bits OR pins, unity chosen by source bit
    // ==========================================================================
    always_comb
    begin
        ctl.clear = ctrl[BRM_CTRL_CLEAR] | clear_in;
        ctl.halt = ctrl[BRM_CTRL_HALT] | count_enable_n_in;
        ctl.strobe = ctrl[BRM_CTRL_STROBE] | strobe_in;
        ctl.unity = ctrl[BRM_CTRL_UNITY_PIN] ? unity_cascade_in : ctrl[BRM_CTRL_UNITY];
    end

    // ==========================================================================
    // Rate decode: bit k fires on states whose lowest set bit is 5-k
    // ==========================================================================
    // Lowest-set-bit decode keeps the gated states disjoint, so pulses never merge.
    genvar k;
    generate
        for (k = 0; k < BRM_CNT_W; k++)
        begin : g_rate
            localparam int P = BRM_CNT_W - 1 - k;
            if (P == 0)
            begin : g_lsb
                assign hit[k] = rate[k] & cnt[0];
            end
            else
            begin : g_upper
                assign hit[k] = rate[k] & cnt[P] & (cnt[P-1:0] == '0);
            end
        end
    endgenerate

    // Rate word is sampled live, so software may change it at any time
    assign rate_hit = |hit;

    // ==========================================================================
    // Counter and pulse outputs
    // ==========================================================================
    always_comb
    begin
        next_cnt = cnt;
        next_pulses = pulses;
        if (ctl.clear)
        begin
            next_cnt = BRM_CNT_ZERO;
        end
        else if (clock_tick && !ctl.halt && !ctl.strobe)
        begin
            next_cnt = cnt + 6'h01;
        end
        // Z pulses last one pclk cycle per gated input clock
        next_z_n = !(clock_tick && !ctl.strobe && !ctl.clear && !ctl.halt && rate_hit);
        // Y is the inverse of the selected unity level (register bit or pin) between Z pulses, so a clock on unity passes through inverted
        next_y_out = !(ctl.unity && next_z_n);
        // Enable out low for the whole input clock period spent at full count
        next_enable_n_out = !(cnt == BRM_CNT_MAX && !ctl.halt && !ctl.clear);
        if (!next_z_n)
        begin
            next_pulses = pulses + 16'h0001;
        end
        if (setup && pwrite && paddr == BRM_OFF_PULSES)
        begin
            next_pulses = 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= BRM_CNT_ZERO;
            pulses <= 16'h0000;
            z_n <= 1'b1;
            y_out <= 1'b0;
            enable_n_out <= 1'b1;
        end
        else
        begin
            cnt <= next_cnt;
            pulses <= next_pulses;
            z_n <= next_z_n;
            y_out <= next_y_out;
            enable_n_out <= next_enable_n_out;
        end
    end

    // ==========================================================================
    // APB slave: zero wait states, CTRL and RATE writes commit in the access phase, a PULSES write clears in setup
    // ==========================================================================
    assign setup = psel && !penable;
    assign mapped = (paddr == BRM_OFF_CTRL) || (paddr == BRM_OFF_RATE) ||
                    (paddr == BRM_OFF_STATUS) || (paddr == BRM_OFF_PULSES);

    always_comb
    begin
        next_ctrl = ctrl;
        next_rate = rate;
        next_prdata = prdata;
        next_pready = setup;
        next_pslverr = setup && !mapped;
        if (psel && penable && pready && pwrite && pstrb[0])
        begin
            if (paddr == BRM_OFF_CTRL)
            begin
                next_ctrl = pwdata[BRM_CTRL_W-1:0];
            end
            if (paddr == BRM_OFF_RATE)
            begin
                next_rate = pwdata[BRM_CNT_W-1:0];
            end
        end
        if (setup && !pwrite)
        begin
            next_prdata = '0;
            unique case (paddr)
                BRM_OFF_CTRL: next_prdata[BRM_CTRL_W-1:0] = ctrl;
                BRM_OFF_RATE: next_prdata[BRM_CNT_W-1:0] = rate;
                BRM_OFF_STATUS:
                begin
                    next_prdata[BRM_CNT_W-1:0] = cnt;
                    next_prdata[BRM_STAT_ENA] = enable_n_out;
                    next_prdata[BRM_STAT_Z] = z_n;
                    next_prdata[BRM_STAT_Y] = y_out;
                end
                BRM_OFF_PULSES: next_prdata[15:0] = pulses;
                default: next_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= BRM_CTRL_RST;
            rate <= BRM_RATE_RST;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            rate <= next_rate;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule : brm_top

//--- bench/brm_tick_src.sv
// Model of the input-clock source feeding the multiplier
module brm_tick_src (
    input wire logic pclk, // bus clock
    input wire logic presetn, // reset, active low
    input wire logic start, // begin a burst
    input wire logic [7:0] n, // edges in the burst
    output logic clock_tick, // rising input-clock edge
    output logic busy // burst running
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] left;
    assign busy = (left != 9'h000) || clock_tick;
    // Ticks on alternate cycles, so the input clock keeps a real low half
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {left, clock_tick} <= 10'h000;
        else
            {left, clock_tick} <= start ? {n, 2'h0} : {left - 9'(left != 9'h000), left[0]};
endmodule : brm_tick_src

//--- bench/brm_top_sva.sv
// Checker for the multiplier pins and the bus handshake
module brm_chk (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic clock_tick, // tick
    input wire logic clear_in, // clear
    input wire logic count_enable_n_in, // halt
    input wire logic strobe_in, // strobe
    input wire logic z_n, // pulse
    input wire logic y_out, // complement
    input wire logic enable_n_out // carry
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Pin relations
    logic run_q;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            run_q <= 1'b0;
        else
            run_q <= clock_tick & ~clear_in & ~strobe_in & ~count_enable_n_in;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_z_needs_run: assert property (!z_n |-> run_q) else $error("stray pulse");
    a_strobe_blocks: assert property (strobe_in |=> z_n) else $error("pulse under strobe");
    a_halt_blocks: assert property (count_enable_n_in |=> z_n) else $error("pulse while halted");
    a_y_with_z: assert property (!z_n |-> y_out) else $error("complement missing");
    a_clear_idle: assert property (clear_in [*2] |-> z_n && enable_n_out) else $error("clear ignored");
    a_carry_run: assert property (!enable_n_out |-> !$past(clear_in) && !$past(count_enable_n_in))
        else $error("carry while stopped");
    a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready) else $error("bad ready");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    c_carry: cover property ($fell(enable_n_out));
    c_pulse: cover property (!z_n ##2 !z_n);
    c_err: cover property (pslverr);
endmodule : brm_chk

bind brm_top brm_chk i_brm_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .clock_tick, .clear_in,
    .count_enable_n_in, .strobe_in, .z_n, .y_out, .enable_n_out);

//--- bench/test_binary_rate_multiplier_6bit.sv
// Self-checking bench for the rate multiplier
module test_binary_rate_multiplier_6bit
    import brm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
    logic clear_in = 1'b0, count_enable_n_in = 1'b0, strobe_in = 1'b0, unity_cascade_in = 1'b0;
    logic [7:0] paddr = 8'h00, n = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, clock_tick, busy, z_n, y_out, enable_n_out, yp, ep;
    logic [5:0] rates [9] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3f, 6'h28};
    int err_count = 0, tests_run = 0, zc = 0, yc = 0, ec = 0;
    brm_top i_brm_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
        .pready, .pslverr, .clock_tick, .clear_in, .count_enable_n_in, .strobe_in, .unity_cascade_in, .z_n,
        .y_out, .enable_n_out);
    brm_tick_src i_brm_tick_src (.pclk, .presetn, .start, .n, .clock_tick, .busy);
    initial forever #5 pclk = ~pclk;
    // ====
    // Pulse counters, free running; tests take differences
    always @(posedge pclk)
    begin
        zc <= zc + int'(z_n === 1'b0);
        yc <= yc + int'(y_out === 1'b1 && yp === 1'b0);
        ec <= ec + int'(enable_n_out === 1'b0 && ep === 1'b1);
        {yp, ep} <= {y_out, enable_n_out};
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        err_count += int'(got !== exp);
        if (got !== exp)
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    endtask : chk
    // For a read, d is the expected data
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && ++t < 50);
        q = prdata;
        chk("ready", {31'h0, pready}, 32'h1);
        chk("error flag", {31'h0, pslverr}, {31'h0, a > 8'h0c});
        if (!w)
            chk("read data", q, d);
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask : acc
    task automatic burst(input logic [7:0] k, input int m, input int y, input int e);
        int z0, y0, e0;
        repeat (3) @(posedge pclk);
        {z0, y0, e0} = {zc, yc, ec};
        {start, n} <= {1'b1, k};
        @(posedge pclk);
        start <= 1'b0;
        repeat (2) @(posedge pclk);
        while (busy !== 1'b0)
            @(posedge pclk);
        repeat (3) @(posedge pclk);
        chk("rate pulses", zc - z0, m);
        chk("complement pulses", yc - y0, y);
        chk("carry lows", ec - e0, e);
        $display("burst of %0d ticks done", k);
    endtask : burst
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        acc(1'b0, BRM_OFF_CTRL, 32'h08);
        acc(1'b0, 8'h10, 32'h0);
        foreach (rates[i])
        begin
            acc(1'b1, BRM_OFF_RATE, {26'h0, rates[i]});
            burst(8'h40, rates[i], rates[i], 1);
        end
        acc(1'b1, BRM_OFF_CTRL, 32'h00);
        burst(8'h40, 40, 0, 1);
        acc(1'b1, BRM_OFF_CTRL, 32'h08);
        acc(1'b1, BRM_OFF_RATE, 32'h20);
        burst(8'h20, 16, 16, 0);
        acc(1'b1, BRM_OFF_RATE, 32'h01);
        burst(8'h20, 1, 1, 1);
        acc(1'b0, BRM_OFF_STATUS, 32'h300);
        // Sum of every rate pulse so far: 166 in the sweep, then 40, 16 and 1
        acc(1'b0, BRM_OFF_PULSES, 32'hdf);
        acc(1'b1, BRM_OFF_PULSES, 32'h0);
        acc(1'b0, BRM_OFF_PULSES, 32'h0);
        burst(8'h05, 0, 0, 0);
        acc(1'b1, BRM_OFF_RATE, 32'h3f);
        // Strobe, then halt, then clear; the counter sits at five until the clear zeroes it
        for (int i = 0; i < 3; i++)
        begin
            {clear_in, count_enable_n_in, strobe_in} <= 3'h1 << i;
            burst(8'h40, 0, 0, 0);
            acc(1'b0, BRM_OFF_STATUS, (i == 2) ? 32'h300 : 32'h305);
        end
        {clear_in, count_enable_n_in, strobe_in} <= 3'h1;
        // Unity taken from the pin, as a cascaded stage would drive it
        acc(1'b1, BRM_OFF_CTRL, 32'h18);
        repeat (2) @(posedge pclk);
        chk("complement level", {31'h0, y_out}, 32'h1);
        unity_cascade_in <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("complement level", {31'h0, y_out}, 32'h0);
        print_verdict();
    end
    initial
    begin
        #200000;
        err_count++;
        print_verdict();
    end
endmodule : test_binary_rate_multiplier_6bit
